// ===== shared/flash_regs_pkg.sv
// Register map, field layout and crossing types of the flash driver status bank
package flash_regs_pkg;

  localparam logic [7:0] ADDR_LB_CTRL  = 8'h0D;
  localparam logic [7:0] ADDR_LB_TIMER = 8'h0E;
  localparam logic [7:0] ADDR_WDT      = 8'h16;
  localparam logic [7:0] ADDR_STAT1    = 8'h17;
  localparam logic [7:0] ADDR_STAT2    = 8'h18;
  localparam logic [7:0] ADDR_IDENT    = 8'h1A;

  localparam logic [7:0] RST_LB_CTRL  = 8'h00;
  localparam logic [1:0] RST_LB_TIMER = 2'h0;
  localparam logic [7:0] RST_STAT     = 8'h00;
  localparam logic [7:0] RST_PTR      = 8'h00;

  localparam int POS_LB_ENABLE = 7;
  localparam int POS_WDT_BIT   = 0;
  localparam int POS_REDUCTION = 7;
  localparam int POS_BLANK_LIM = 6;

  // Low-battery reset timer codes; 10 and 11 reserved
  localparam logic [1:0] TIMER_CODE_250US = 2'h0;
  localparam logic [1:0] TIMER_CODE_500US = 2'h1;
  localparam int LB_TIME_A_NS  = 250000;
  localparam int LB_TIME_B_NS  = 500000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LB_CYC_A      = LB_TIME_A_NS / CLK_PERIOD_NS;
  localparam int LB_CYC_B      = LB_TIME_B_NS / CLK_PERIOD_NS;

  localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;

  // Fault and event conditions coming from the analog core
  typedef struct packed {
    logic thermistor_short;
    logic gsm_blank_event;
    logic power_good_window;
    logic die_over_temp;
    logic thermistor_trip;
    logic indicator_led_fault;
    logic flash_led_b_fault;
    logic flash_led_a_fault;
    logic low_batt_reduction;
    logic blank_current_limit;
  } fault_conds_s;

  localparam fault_conds_s CONDS_CLEAR = '0;

endpackage

// ===== hdl/core_link_side.sv
// Core clock side: watchdog restart handshake and condition capture
`timescale 1ns/1ps
module core_link_side
  import flash_regs_pkg::*;
(
  input  wire logic         core_clk,          // Core clock
  input  wire logic         rst,               // Synchronous reset, active high
  input  wire logic         restart_req_tgl,   // Restart toggle from ref domain
  input  fault_conds_s      conds_in,          // Raw core conditions
  output fault_conds_s      conds_core,        // Registered conditions
  output logic              restart_ack_tgl,   // Ack toggle back to ref domain
  output logic              watchdog_restart   // One-cycle restart pulse
);

  logic req_meta;
  logic req_sync;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
    end
    else
    begin
      req_meta <= restart_req_tgl;
      req_sync <= req_meta;
    end
  end

  // Ack toggles back on the same edge that issues the restart pulse
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      restart_ack_tgl  <= 1'b0;
      watchdog_restart <= 1'b0;
    end
    else
    begin
      watchdog_restart <= req_sync != restart_ack_tgl;
      restart_ack_tgl  <= req_sync;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      conds_core <= CONDS_CLEAR;
    else
      conds_core <= conds_in;
  end

endmodule

// ===== hdl/flash_driver_status_regs.sv
// Two-wire register bank of the flash driver: timer, watchdog, status, identity
`timescale 1ns/1ps
module flash_driver_status_regs
  import flash_regs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR  = 7'h2A, // Bus address, plain default
  parameter logic [7:0] DIE_IDENT = 8'h42  // Arbitrary value
)
(
  input  wire logic    ref_clk,                   // 100 MHz register clock
  input  wire logic    rst,                       // Synchronous reset, active high
  input  wire logic    core_clk,                  // Core link clock
  input  wire logic    scl,                       // Serial clock pin
  input  wire logic    sda_in,                    // Serial data pin level
  output logic         sda_out,                   // Serial data drive value
  output logic         sda_oe,                    // Serial data drive enable
  input  fault_conds_s conds_in,                  // Core conditions, core domain
  output logic [1:0]   low_batt_timer_sel,        // Low-battery timer code
  output logic         low_batt_reduction_enable, // Reduction enable
  output logic         watchdog_restart           // Restart pulse, core domain
);

  typedef enum logic [8:0] {
    ST_IDLE     = 9'b000000001,
    ST_ADDR     = 9'b000000010,
    ST_ADDR_ACK = 9'b000000100,
    ST_PTR      = 9'b000001000,
    ST_PTR_ACK  = 9'b000010000,
    ST_WDATA    = 9'b000100000,
    ST_WACK     = 9'b001000000,
    ST_RDATA    = 9'b010000000,
    ST_RACK     = 9'b100000000
  } link_state_e;

  link_state_e  state;
  logic [2:0]   scl_pipe;
  logic [2:0]   sda_pipe;
  logic [7:0]   shift;
  logic [3:0]   bit_count;
  logic [7:0]   ptr;
  logic         read_mode;
  logic         master_ack;
  logic         wr_stb;
  logic [7:0]   wr_addr;
  logic [7:0]   wr_data;
  logic         rd_stb;
  logic [7:0]   rd_addr;
  logic [7:0]   lb_ctrl;
  logic [7:0]   stat1;
  logic [1:0]   stat2;
  logic         restart_req_tgl;
  logic         ack_meta;
  logic         ack_sync;
  logic         wdt_pending;
  fault_conds_s conds_core;
  fault_conds_s cond_meta;
  fault_conds_s cond_sync;
  logic         restart_ack_tgl;
  logic [7:0]   cond1;
  logic         scl_rise;
  logic         scl_fall;
  logic         bus_start;
  logic         bus_stop;
  logic [7:0]   load_byte;
  logic [7:0]   stat2_view;

  core_link_side u_core (
    .core_clk        (core_clk),
    .rst             (rst),
    .restart_req_tgl (restart_req_tgl),
    .conds_in        (conds_in),
    .conds_core      (conds_core),
    .restart_ack_tgl (restart_ack_tgl),
    .watchdog_restart(watchdog_restart)
  );

  // Read view of every register; unmapped addresses read zero
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    unique case (a)
      ADDR_LB_CTRL:  read_mux = lb_ctrl;
      ADDR_LB_TIMER: read_mux = {6'h00, low_batt_timer_sel};
      ADDR_WDT:      read_mux = {7'h00, wdt_pending};
      ADDR_STAT1:    read_mux = stat1;
      ADDR_STAT2:    read_mux = {stat2, 6'h00};
      ADDR_IDENT:    read_mux = DIE_IDENT;
      default:       read_mux = 8'h00;
    endcase
  endfunction

  // Pins and core levels cross through two flip-flops
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      scl_pipe  <= 3'h7;
      sda_pipe  <= 3'h7;
      cond_meta <= CONDS_CLEAR;
      cond_sync <= CONDS_CLEAR;
      ack_meta  <= 1'b0;
      ack_sync  <= 1'b0;
    end
    else
    begin
      scl_pipe  <= {scl_pipe[1:0], scl};
      sda_pipe  <= {sda_pipe[1:0], sda_in};
      cond_meta <= conds_core;
      cond_sync <= cond_meta;
      ack_meta  <= restart_ack_tgl;
      ack_sync  <= ack_meta;
    end
  end

  assign scl_rise  = scl_pipe[1] && !scl_pipe[2];
  assign scl_fall  = !scl_pipe[1] && scl_pipe[2];
  assign bus_start = scl_pipe[1] && !sda_pipe[1] && sda_pipe[2];
  assign bus_stop  = scl_pipe[1] && sda_pipe[1] && !sda_pipe[2];
  assign load_byte = read_mux(ptr);
  assign stat2_view = read_mux(ADDR_STAT2);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state      <= ST_IDLE;
      shift      <= 8'h00;
      bit_count  <= 4'h0;
      ptr        <= RST_PTR;
      read_mode  <= 1'b0;
      master_ack <= 1'b0;
      sda_oe     <= 1'b0;
      sda_out    <= 1'b0;
      wr_stb     <= 1'b0;
      wr_addr    <= 8'h00;
      wr_data    <= 8'h00;
      rd_stb     <= 1'b0;
      rd_addr    <= 8'h00;
    end
    else
    begin
      wr_stb  <= 1'b0;
      rd_stb  <= 1'b0;
      sda_out <= 1'b0;
      if (bus_start)
      begin
        state     <= ST_ADDR;
        bit_count <= 4'h0;
        sda_oe    <= 1'b0;
      end
      else if (bus_stop)
      begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (state == ST_RACK)
          master_ack <= !sda_pipe[1];
        else if (state != ST_IDLE)
        begin
          bit_count <= bit_count + 4'h1;
          if (state != ST_RDATA)
            shift <= {shift[6:0], sda_pipe[1]};
        end
      end
      else if (scl_fall)
      begin
        unique case (state)
          ST_IDLE: ;
          ST_ADDR:
            if (bit_count == BIT_COUNT_BYTE)
            begin
              if (shift[7:1] == DEV_ADDR)
              begin
                state     <= ST_ADDR_ACK;
                read_mode <= shift[0];
                sda_oe    <= 1'b1;
              end
              else
                state <= ST_IDLE;
            end
          ST_ADDR_ACK:
          begin
            bit_count <= 4'h0;
            if (read_mode)
            begin
              state   <= ST_RDATA;
              shift   <= load_byte;
              sda_oe  <= !load_byte[7];
              rd_stb  <= 1'b1;
              rd_addr <= ptr;
              ptr     <= ptr + 8'h01;
            end
            else
            begin
              state  <= ST_PTR;
              sda_oe <= 1'b0;
            end
          end
          ST_PTR:
            if (bit_count == BIT_COUNT_BYTE)
            begin
              ptr    <= shift;
              state  <= ST_PTR_ACK;
              sda_oe <= 1'b1;
            end
          ST_PTR_ACK, ST_WACK:
          begin
            state     <= ST_WDATA;
            bit_count <= 4'h0;
            sda_oe    <= 1'b0;
          end
          ST_WDATA:
            if (bit_count == BIT_COUNT_BYTE)
            begin
              wr_stb  <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shift;
              ptr     <= ptr + 8'h01;
              state   <= ST_WACK;
              sda_oe  <= 1'b1;
            end
          ST_RDATA:
            if (bit_count == BIT_COUNT_BYTE)
            begin
              state  <= ST_RACK;
              sda_oe <= 1'b0;
            end
            else
            begin
              shift  <= {shift[6:0], 1'b0};
              sda_oe <= !shift[6];
            end
          ST_RACK:
            if (master_ack)
            begin
              state     <= ST_RDATA;
              bit_count <= 4'h0;
              shift     <= load_byte;
              sda_oe    <= !load_byte[7];
              rd_stb    <= 1'b1;
              rd_addr   <= ptr;
              ptr       <= ptr + 8'h01;
            end
            else
              state <= ST_IDLE;
        endcase
      end
    end
  end

  // Writable control; status and identifier writes fall through
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      lb_ctrl            <= RST_LB_CTRL;
      low_batt_timer_sel <= RST_LB_TIMER;
      low_batt_reduction_enable <= 1'b0;
    end
    else if (wr_stb)
    begin
      if (wr_addr == ADDR_LB_CTRL)
      begin
        lb_ctrl                   <= wr_data;
        low_batt_reduction_enable <= wr_data[POS_LB_ENABLE];
      end
      if (wr_addr == ADDR_LB_TIMER)
        low_batt_timer_sel <= wr_data[1:0];
    end
  end

  // Toggle per restart; the bit reads set until the core acks
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      restart_req_tgl <= 1'b0;
    else if (wr_stb && wr_addr == ADDR_WDT && wr_data[POS_WDT_BIT])
      restart_req_tgl <= !restart_req_tgl;
  end

  assign wdt_pending = restart_req_tgl != ack_sync;

  assign cond1 = {cond_sync.thermistor_short,
                  cond_sync.gsm_blank_event,
                  cond_sync.power_good_window,
                  cond_sync.die_over_temp,
                  cond_sync.thermistor_trip,
                  cond_sync.indicator_led_fault,
                  cond_sync.flash_led_b_fault,
                  cond_sync.flash_led_a_fault};

  // Set beats the read clear so a persisting fault is never lost
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stat1 <= RST_STAT;
      stat2 <= 2'h0;
    end
    else
    begin
      stat1 <= (rd_stb && rd_addr == ADDR_STAT1 ? 8'h00 : stat1) | cond1;
      stat2 <= (rd_stb && rd_addr == ADDR_STAT2 ? 2'h0 : stat2)
             | {cond_sync.low_batt_reduction && low_batt_reduction_enable,
                cond_sync.blank_current_limit};
    end
  end

  a_fault_sets: assert property (@(posedge ref_clk) disable iff (rst)
    cond_sync.thermistor_short |=> stat1[7])
    else $error("thermistor short not latched");

  a_led_a_sets: assert property (@(posedge ref_clk) disable iff (rst)
    cond_sync.flash_led_a_fault |=> stat1[0])
    else $error("flash LED A fault not latched");

  a_read_clears: assert property (@(posedge ref_clk) disable iff (rst)
    rd_stb && rd_addr == ADDR_STAT1 && cond1 == 8'h00 |=> stat1 == 8'h00)
    else $error("status read did not clear");

  a_flag_holds: assert property (@(posedge ref_clk) disable iff (rst)
    stat1[4] && !(rd_stb && rd_addr == ADDR_STAT1) |=> stat1[4])
    else $error("latched flag dropped without read");

  a_limit_sets: assert property (@(posedge ref_clk) disable iff (rst)
    cond_sync.blank_current_limit |=> stat2[0] && stat2_view[POS_BLANK_LIM])
    else $error("blank current limit flag missing");

  a_reduction_gated: assert property (@(posedge ref_clk) disable iff (rst)
    !low_batt_reduction_enable && !stat2[1] |=> !stat2[1])
    else $error("reduction flag set while disabled");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
    stat2_view[5:0] == 6'h00 && (read_mux(ADDR_WDT) & 8'hFE) == 8'h00)
    else $error("reserved bits not zero");

  a_ident_fixed: assert property (@(posedge ref_clk) disable iff (rst)
    wr_stb && wr_addr == ADDR_IDENT |=> read_mux(ADDR_IDENT) == DIE_IDENT)
    else $error("identifier changed");

  a_timer_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_stb && wr_addr == ADDR_LB_TIMER |=> low_batt_timer_sel == wr_data[1:0])
    else $error("timer field not stored");

  a_wdt_pending: assert property (@(posedge ref_clk) disable iff (rst)
    wr_stb && wr_addr == ADDR_WDT && wr_data[0] && !wdt_pending |=> wdt_pending)
    else $error("watchdog bit not set by write");

  a_wdt_selfclear: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(wdt_pending) |-> ##[1:120] !wdt_pending)
    else $error("watchdog bit never cleared");

endmodule

// ===== testbench/i2c_host_model.sv
// Two-wire host model that masters the register bank
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] ADDR = 7'h2A // Bus address of the bank
)
(
  input  wire logic ref_clk,  // Bit timing clock
  input  wire logic sda_line, // Resolved data line
  output logic      scl,      // Serial clock, idles high
  output logic      sda_low   // High pulls data low
);
  logic [6:0] dev_addr = ADDR;
  int         half     = 8;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Data moves two cycles after the clock falls, so it never races the fall
  task automatic bit_xfer(input logic b, output logic seen);
    sda_low <= ~b;
    hold(half);
    scl <= 1'b1;
    hold(half);
    seen = sda_line;
    scl <= 1'b0;
    hold(2);
  endtask

  // Serves as both first and repeated start
  task automatic start_cond;
    sda_low <= 1'b0;
    hold(half);
    scl <= 1'b1;
    hold(half);
    sda_low <= 1'b1;
    hold(half);
    scl <= 1'b0;
    hold(2);
  endtask

  task automatic stop_cond;
    sda_low <= 1'b1;
    hold(half);
    scl <= 1'b1;
    hold(half);
    sda_low <= 1'b0;
    hold(half);
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_seen);
    for (int i = 7; i >= 0; i--)
      bit_xfer(tx[i], rx[i]);
    bit_xfer(ack_in, ack_seen);
  endtask

  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    start_cond();
    xfer({dev_addr, 1'b0}, 1'b1, rx, a0);
    xfer(ptr, 1'b1, rx, a1);
    xfer(data, 1'b1, rx, a2);
    stop_cond();
    ok = !a0 && !a1 && !a2;
  endtask

  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       nack;
    start_cond();
    xfer({dev_addr, 1'b0}, 1'b1, rx, a0);
    xfer(ptr, 1'b1, rx, a1);
    start_cond();
    xfer({dev_addr, 1'b1}, 1'b1, rx, a2);
    xfer(8'hFF, 1'b1, data, nack);
    stop_cond();
    ok = !a0 && !a1 && !a2;
  endtask
endmodule

// ===== testbench/flash_driver_status_regs_bench.sv
// Self-checking bench of the flash driver status register bank
`timescale 1ns/1ps
module flash_driver_status_regs_bench;
  import flash_regs_pkg::*;

  localparam logic [7:0] IDENT = 8'h42; // Arbitrary value

  logic         ref_clk    = 1'b0;
  logic         core_clk   = 1'b0;
  logic         rst        = 1'b1;
  logic         scl;
  logic         sda_low;
  logic         sda_out;
  logic         sda_oe;
  logic         sda_line;
  logic [1:0]   low_batt_timer_sel;
  logic         low_batt_reduction_enable;
  logic         watchdog_restart;
  fault_conds_s conds_in   = CONDS_CLEAR;
  int           fail_count = 0;
  int           checked    = 0;
  int           pulses     = 0;

  always #5 ref_clk = ~ref_clk;

  // Link edges land on ref_clk falling edges, clear of its sampling edge
  always #80 core_clk = ~core_clk;

  // Open drain with pull-up
  assign sda_line = !((sda_oe && !sda_out) || sda_low);

  always @(posedge core_clk)
    if (watchdog_restart === 1'b1)
      pulses <= pulses + 1;

  flash_driver_status_regs #(.DEV_ADDR(7'h2A), .DIE_IDENT(IDENT)) dut (
    .ref_clk(ref_clk), .rst(rst), .core_clk(core_clk), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .conds_in(conds_in),
    .low_batt_timer_sel(low_batt_timer_sel),
    .low_batt_reduction_enable(low_batt_reduction_enable),
    .watchdog_restart(watchdog_restart));

  i2c_host_model #(.ADDR(7'h2A)) host (
    .ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.read_reg(ptr, d, ok);
    check({7'h0, ok}, 8'h01, "read ack");
    check(d, exp, $sformatf("read %h", ptr));
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    logic ok;
    host.write_reg(ptr, data, ok);
    check({7'h0, ok}, 8'h01, "write ack");
  endtask

  // Held four link cycles so the core side surely samples it
  task automatic pulse(input logic [9:0] v);
    conds_in <= fault_conds_s'(v);
    repeat (64) @(posedge ref_clk);
    conds_in <= CONDS_CLEAR;
    repeat (64) @(posedge ref_clk);
  endtask

  task automatic test_reset;
    check({6'h0, low_batt_timer_sel}, 8'h00, "timer at reset");
    check({7'h0, low_batt_reduction_enable}, 8'h00, "enable at reset");
    rd(ADDR_LB_TIMER, 8'h00);
    rd(ADDR_WDT, 8'h00);
    rd(ADDR_LB_CTRL, 8'h00);
    rd(ADDR_IDENT, IDENT);
    $display("test_reset done");
  endtask

  task automatic test_timer;
    host.half = 20;
    wr(ADDR_LB_TIMER, 8'hFD);
    host.half = 8;
    check({6'h0, low_batt_timer_sel}, 8'h01, "timer code 01");
    rd(ADDR_LB_TIMER, 8'h01);
    wr(ADDR_LB_TIMER, 8'h00);
    check({6'h0, low_batt_timer_sel}, 8'h00, "timer code 00");
    rd(ADDR_LB_TIMER, 8'h00);
    $display("test_timer done");
  endtask

  task automatic test_watchdog;
    int p0;
    int n;
    p0 = pulses;
    n = 0;
    wr(ADDR_WDT, 8'hFF);
    while (pulses == p0 && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
    check({7'h0, n < 300}, 8'h01, "restart wait");
    repeat (150) @(posedge ref_clk);
    check(8'(pulses - p0), 8'h01, "restart pulses");
    rd(ADDR_WDT, 8'h00);
    $display("test_watchdog done");
  endtask

  task automatic test_fault_status_primary;
    for (int b = 0; b < 8; b++)
    begin
      pulse(10'h004 << b);
      rd(ADDR_STAT1, 8'h01 << b);
      rd(ADDR_STAT1, 8'h00);
    end
    $display("test_fault_status_primary done");
  endtask

  task automatic test_persist;
    conds_in <= fault_conds_s'(10'h200);
    repeat (64) @(posedge ref_clk);
    rd(ADDR_STAT1, 8'h80);
    rd(ADDR_STAT1, 8'h80);
    wr(ADDR_STAT1, 8'h00);
    conds_in <= CONDS_CLEAR;
    repeat (64) @(posedge ref_clk);
    rd(ADDR_STAT1, 8'h80);
    rd(ADDR_STAT1, 8'h00);
    wr(ADDR_IDENT, 8'h00);
    rd(ADDR_IDENT, IDENT);
    wr(ADDR_STAT2, 8'hFF);
    rd(ADDR_STAT2, 8'h00);
    $display("test_persist done");
  endtask

  task automatic test_event_status_secondary;
    pulse(10'h002);
    rd(ADDR_STAT2, 8'h00);
    wr(ADDR_LB_CTRL, 8'h80);
    check({7'h0, low_batt_reduction_enable}, 8'h01, "enable set");
    pulse(10'h002);
    rd(ADDR_STAT2, 8'h80);
    pulse(10'h001);
    rd(ADDR_STAT2, 8'h40);
    rd(ADDR_STAT2, 8'h00);
    $display("test_event_status_secondary done");
  endtask

  task automatic test_refused;
    logic ok;
    rd(8'h30, 8'h00);
    host.dev_addr = 7'h11;
    host.write_reg(ADDR_LB_TIMER, 8'h01, ok);
    host.dev_addr = 7'h2A;
    check({7'h0, ok}, 8'h00, "foreign address acked");
    rd(ADDR_LB_TIMER, 8'h00);
    $display("test_refused done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Reset counted in link cycles so the slow core side sees it too
  initial
  begin
    repeat (10) @(posedge core_clk);
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    test_reset();
    test_timer();
    test_watchdog();
    test_fault_status_primary();
    test_persist();
    test_event_status_secondary();
    test_refused();
    test_done();
  end

  initial
  begin
    repeat (95000) @(posedge ref_clk);
    fail_count++;
    $display("[FAIL] %0t run did not finish", $time);
    test_done();
  end
endmodule
